// ===== servo_input_device_decoder.sv
// Decoder for the discrete input devices of a servo drive.
// Assumes an AXI4-Lite master on sys_clk and asynchronous input pins.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module servo_input_device_decoder #(
   parameter bit SINGLE_AXIS = 1'b1
) (
   input  wire logic                               sys_clk,
   input  wire logic                               reset,
   // Input devices
   input  wire logic                               forced_stop_decel_in,
   input  wire logic                               forced_stop_brake_in,
   input  wire logic                               fwd_limit_in,
   input  wire logic                               rev_limit_in,
   input  wire logic                               prop_ctrl_in,
   input  wire logic                               gain_sel_in,
   input  wire logic                               gain_sel2_in,
   input  wire logic                               closed_loop_sel_in,
   input  wire logic                               home_sensor_in,
   input  wire logic                               probe_latch_in_a,
   input  wire logic                               probe_latch_in_b,
   input  wire logic                               probe_latch_in_c,
   // From the drive core
   input  wire logic                               alarm,
   input  wire logic                               motorStopped,
   input  wire logic [servo_input_pkg::POS_W-1:0]  curPosition,
   // Decoded outputs
   output logic                                    decelStopReq,
   output logic                                    powerStageOff,
   output logic                                    dynBrakeOn,
   output logic                                    brake_interlock_out,
   output logic                                    fwdEnable,
   output logic                                    revEnable,
   output logic                                    servoLock,
   output logic                                    propOnly,
   output logic [1:0]                              gainSet,
   output logic                                    fullyClosed,
   output logic                                    homeDetect,
   output logic [2:0]                              probeStrobe,
   // AXI4-Lite slave
   input  wire logic [7:0]                         s_axi_awaddr,
   input  wire logic                               s_axi_awvalid,
   output logic                                    s_axi_awready,
   input  wire logic [31:0]                        s_axi_wdata,
   input  wire logic [3:0]                         s_axi_wstrb,
   input  wire logic                               s_axi_wvalid,
   output logic                                    s_axi_wready,
   output logic [1:0]                              s_axi_bresp,
   output logic                                    s_axi_bvalid,
   input  wire logic                               s_axi_bready,
   input  wire logic [7:0]                         s_axi_araddr,
   input  wire logic                               s_axi_arvalid,
   output logic                                    s_axi_arready,
   output logic [31:0]                             s_axi_rdata,
   output logic [1:0]                              s_axi_rresp,
   output logic                                    s_axi_rvalid,
   input  wire logic                               s_axi_rready
);

   // ----------------------------------------------------------------
   // Synchronised inputs
   // ----------------------------------------------------------------
   logic [servo_input_pkg::IN_COUNT-1:0] syncIn;
   logic decelIn, brakeIn, fwdIn, revIn, propIn, gainIn, gain2In, loopIn, homeIn;
   logic [2:0] probeIn;
   logic alarmSeen;

   input_sync u_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .rawIn   ({probe_latch_in_c, probe_latch_in_b, probe_latch_in_a, home_sensor_in,
                 closed_loop_sel_in, gain_sel2_in, gain_sel_in, prop_ctrl_in,
                 rev_limit_in, fwd_limit_in, forced_stop_brake_in, forced_stop_decel_in}),
      .syncOut (syncIn)
   );

   assign decelIn = syncIn[0];
   assign brakeIn = syncIn[1];
   assign fwdIn   = syncIn[2];
   assign revIn   = syncIn[3];
   assign propIn  = syncIn[4];
   assign gainIn  = syncIn[5];
   assign gain2In = syncIn[6];
   assign loopIn  = syncIn[7];
   assign homeIn  = syncIn[8];
   assign probeIn = syncIn[11:9];
   assign alarmSeen = alarm;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [1:0] stopMethod_r;
   logic       stopInput_r;
   logic       loopSwitch_r;
   logic       homePol_r;
   logic [2:0] probeEn_r;
   logic [servo_input_pkg::POS_W-1:0] latchPos_r [3];

   // ----------------------------------------------------------------
   // Stop input selection
   // ----------------------------------------------------------------
   logic useDecel, useBrake, decelStopActive, brakeStopActive;

   assign useDecel = !stopInput_r && stopMethod_r == servo_input_pkg::STOP_DECEL;
   assign useBrake = !stopInput_r && stopMethod_r == servo_input_pkg::STOP_NO_DECEL;
   // Stop input cfg 1 masks both forced-stop inputs
   assign decelStopActive = useDecel && !decelIn;
   assign brakeStopActive = useBrake && !brakeIn;

   // ----------------------------------------------------------------
   // Stop sequencer
   // ----------------------------------------------------------------
   servo_input_pkg::stop_state_e state_r;
   logic [11:0] decelCnt_r;
   logic        withDecel;

   // Method 2 means decelerate before the interlock drops
   assign withDecel = stopMethod_r == servo_input_pkg::STOP_DECEL;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r    <= servo_input_pkg::ST_RUN;
         decelCnt_r <= 12'h000;
      end else begin
         case (state_r)
            servo_input_pkg::ST_RUN: begin
               if (decelStopActive || (alarmSeen && withDecel)) begin
                  state_r    <= servo_input_pkg::ST_DECEL;
                  decelCnt_r <= servo_input_pkg::DECEL_CYCLES;
               end else if (brakeStopActive || alarmSeen) begin
                  state_r <= servo_input_pkg::ST_BRAKE;
               end
            end
            servo_input_pkg::ST_DECEL: begin
               if (!decelStopActive && !alarmSeen) begin
                  state_r <= servo_input_pkg::ST_RUN;
               end else if (motorStopped || decelCnt_r == 12'h000) begin
                  state_r <= servo_input_pkg::ST_HELD;
               end else begin
                  decelCnt_r <= decelCnt_r - 12'h001;
               end
            end
            servo_input_pkg::ST_BRAKE: begin
               if (!brakeStopActive && !alarmSeen) begin
                  state_r <= servo_input_pkg::ST_RUN;
               end
            end
            servo_input_pkg::ST_HELD: begin
               if (!decelStopActive && !alarmSeen) begin
                  state_r <= servo_input_pkg::ST_RUN;
               end
            end
            default: state_r <= servo_input_pkg::ST_RUN;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         decelStopReq        <= 1'b0;
         powerStageOff       <= 1'b0;
         dynBrakeOn          <= 1'b0;
         brake_interlock_out <= 1'b0;
      end else begin
         decelStopReq  <= state_r == servo_input_pkg::ST_DECEL;
         powerStageOff <= state_r == servo_input_pkg::ST_BRAKE
                          || state_r == servo_input_pkg::ST_HELD;
         dynBrakeOn    <= state_r == servo_input_pkg::ST_BRAKE;
         // Interlock stays on through deceleration, off once braking
         brake_interlock_out <= state_r == servo_input_pkg::ST_RUN
                                || state_r == servo_input_pkg::ST_DECEL;
      end
   end

   // ----------------------------------------------------------------
   // Direction, amplifier, gain, loop and home decoding
   // ----------------------------------------------------------------
   function automatic logic [1:0] gain_pick(input logic g1, input logic g2);
      if (g2) begin
         gain_pick = servo_input_pkg::GAIN_SET_THIRD;
      end else if (g1) begin
         gain_pick = servo_input_pkg::GAIN_SET_SECOND;
      end else begin
         gain_pick = servo_input_pkg::GAIN_SET_FIRST;
      end
   endfunction : gain_pick

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         fwdEnable   <= 1'b0;
         revEnable   <= 1'b0;
         servoLock   <= 1'b0;
         propOnly    <= 1'b0;
         gainSet     <= servo_input_pkg::GAIN_SET_FIRST;
         fullyClosed <= 1'b0;
         homeDetect  <= 1'b0;
      end else begin
         fwdEnable   <= fwdIn;
         revEnable   <= revIn;
         servoLock   <= !fwdIn || !revIn;
         propOnly    <= propIn;
         gainSet     <= gain_pick(gainIn, gain2In);
         fullyClosed <= loopSwitch_r && loopIn;
         homeDetect  <= homeIn == homePol_r;
      end
   end

   // ----------------------------------------------------------------
   // Touch probe latching
   // ----------------------------------------------------------------
   logic [2:0] probePrev_r;
   logic [2:0] probeRise;

   assign probeRise = probeIn & ~probePrev_r & probeEn_r;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         probePrev_r <= 3'h0;
         probeStrobe <= 3'h0;
         latchPos_r[0] <= '0;
         latchPos_r[1] <= '0;
         latchPos_r[2] <= '0;
      end else begin
         probePrev_r <= probeIn;
         probeStrobe <= probeRise;
         for (int i = 0; i < 3; i++) begin
            if (probeRise[i]) begin
               latchPos_r[i] <= curPosition;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   logic [7:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;
   logic        doWrite;

   assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         awAddr_r     <= 8'h00;
         wData_r      <= 32'h00000000;
         wStrb_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= servo_input_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_r == servo_input_pkg::CFG_OFFSET
                             || awAddr_r == servo_input_pkg::PROBE_OFFSET)
                            ? servo_input_pkg::RESP_OKAY : servo_input_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stopMethod_r <= servo_input_pkg::STOP_METHOD_RESET;
         stopInput_r  <= servo_input_pkg::STOP_INPUT_RESET;
         loopSwitch_r <= servo_input_pkg::LOOP_SWITCH_RESET;
         homePol_r    <= servo_input_pkg::HOME_POL_RESET;
         probeEn_r    <= SINGLE_AXIS ? servo_input_pkg::PROBE_EN_SINGLE
                                     : servo_input_pkg::PROBE_EN_MULTI;
      end else if (doWrite && wStrb_r[0]) begin
         if (awAddr_r == servo_input_pkg::CFG_OFFSET) begin
            stopMethod_r <= wData_r[servo_input_pkg::STOP_METHOD_LSB +: 2];
            stopInput_r  <= wData_r[servo_input_pkg::STOP_INPUT_BIT];
            loopSwitch_r <= wData_r[servo_input_pkg::LOOP_SWITCH_BIT];
            homePol_r    <= wData_r[servo_input_pkg::HOME_POL_BIT];
         end else if (awAddr_r == servo_input_pkg::PROBE_OFFSET) begin
            probeEn_r <= wData_r[servo_input_pkg::PROBE_EN_LSB +: 3];
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= servo_input_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0;
         s_axi_rresp  <= servo_input_pkg::RESP_OKAY;
         if (s_axi_araddr == servo_input_pkg::CFG_OFFSET) begin
            s_axi_rdata <= {25'h0, homePol_r, loopSwitch_r, stopInput_r, 2'h0, stopMethod_r};
         end else if (s_axi_araddr == servo_input_pkg::PROBE_OFFSET) begin
            s_axi_rdata <= {29'h0, probeEn_r};
         end else if (s_axi_araddr == servo_input_pkg::STATUS_OFFSET) begin
            s_axi_rdata <= {16'h0, state_r, gainSet, fullyClosed, homeDetect,
                            propOnly, servoLock, revEnable, fwdEnable,
                            brake_interlock_out, dynBrakeOn, powerStageOff, decelStopReq};
         end else if (s_axi_araddr == servo_input_pkg::POS_A_OFFSET) begin
            s_axi_rdata <= latchPos_r[0];
         end else if (s_axi_araddr == servo_input_pkg::POS_B_OFFSET) begin
            s_axi_rdata <= latchPos_r[1];
         end else if (s_axi_araddr == servo_input_pkg::POS_C_OFFSET) begin
            s_axi_rdata <= latchPos_r[2];
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= servo_input_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : servo_input_device_decoder

`default_nettype wire

// ===== servo_input_pkg.sv
// Constants and encodings for the servo input device decoder.
// Assumes a single 20 MHz system clock and an AXI4-Lite register bus.
package servo_input_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG_OFFSET    = 8'h00;
   localparam logic [7:0] PROBE_OFFSET  = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] POS_A_OFFSET  = 8'h0c;
   localparam logic [7:0] POS_B_OFFSET  = 8'h10;
   localparam logic [7:0] POS_C_OFFSET  = 8'h14;

   // ----------------------------------------------------------------
   // Configuration field positions
   // ----------------------------------------------------------------
   localparam int STOP_METHOD_LSB  = 0;
   localparam int STOP_INPUT_BIT   = 4;
   localparam int LOOP_SWITCH_BIT  = 5;
   localparam int HOME_POL_BIT     = 6;
   localparam int PROBE_EN_LSB     = 0;

   // ----------------------------------------------------------------
   // Field values and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] STOP_NO_DECEL = 2'h0;
   localparam logic [1:0] STOP_DECEL    = 2'h2;
   localparam logic [1:0] STOP_METHOD_RESET = 2'h0;
   localparam logic       STOP_INPUT_RESET  = 1'h0;
   localparam logic       LOOP_SWITCH_RESET = 1'h0;
   localparam logic       HOME_POL_RESET    = 1'h0;
   localparam logic [2:0] PROBE_EN_SINGLE   = 3'h3;
   localparam logic [2:0] PROBE_EN_MULTI    = 3'h0;

   // ----------------------------------------------------------------
   // Timing and widths
   // ----------------------------------------------------------------
   localparam int           CLK_MHZ        = 20;
   localparam int           DECEL_TIME_US  = 100;
   localparam logic [11:0]  DECEL_CYCLES   = 12'(DECEL_TIME_US * CLK_MHZ);
   localparam int           POS_W          = 32;
   localparam int           IN_COUNT       = 12;

   // Gain set selection
   localparam logic [1:0] GAIN_SET_FIRST  = 2'h0;
   localparam logic [1:0] GAIN_SET_SECOND = 2'h1;
   localparam logic [1:0] GAIN_SET_THIRD  = 2'h2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Stop sequencing states
   typedef enum logic [3:0] {
      ST_RUN   = 4'h1,
      ST_DECEL = 4'h2,
      ST_BRAKE = 4'h4,
      ST_HELD  = 4'h8
   } stop_state_e;

endpackage : servo_input_pkg

// ===== input_sync.sv
// Two-stage synchroniser bank for the discrete input devices.
// Assumes inputs are asynchronous levels from switches and sensors.
`timescale 1ns/100ps
`default_nettype none

module input_sync (
   input  wire logic                                  sys_clk,
   input  wire logic                                  reset,
   input  wire logic [servo_input_pkg::IN_COUNT-1:0]  rawIn,
   output logic      [servo_input_pkg::IN_COUNT-1:0]  syncOut
);

   logic [servo_input_pkg::IN_COUNT-1:0] stage1_r;

   // ----------------------------------------------------------------
   // Two flip-flops per input
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stage1_r <= '0;
         syncOut  <= '0;
      end else begin
         stage1_r <= rawIn;
         syncOut  <= stage1_r;
      end
   end

endmodule : input_sync

`default_nettype wire

// ===== servo_input_monitor.sv
// Checker on the decoder top-level ports.
// Assumes it is bound onto servo_input_device_decoder.
`timescale 1ns/100ps
`default_nettype none

module servo_input_monitor (
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic       fwd_limit_in,
   input wire logic       rev_limit_in,
   input wire logic       prop_ctrl_in,
   input wire logic       gain_sel_in,
   input wire logic       gain_sel2_in,
   input wire logic       probe_latch_in_a,
   input wire logic       fwdEnable,
   input wire logic       revEnable,
   input wire logic       servoLock,
   input wire logic       propOnly,
   input wire logic [1:0] gainSet,
   input wire logic [2:0] probeStrobe,
   input wire logic       dynBrakeOn,
   input wire logic       powerStageOff,
   input wire logic       decelStopReq,
   input wire logic       brake_interlock_out
);
   logic [2:0] upCnt_r;
   logic       rdy;

   // Settle count so history never reaches back into reset
   always_ff @(posedge sys_clk) begin
      if (reset) upCnt_r <= 3'h0;
      else if (upCnt_r != 3'h7) upCnt_r <= upCnt_r + 3'h1;
   end
   assign rdy = (upCnt_r == 3'h7);

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_fwd_follow: assert property (rdy |-> fwdEnable == $past(fwd_limit_in, 3))
      else $error("forward enable wrong");
   a_rev_follow: assert property (rdy |-> revEnable == $past(rev_limit_in, 3))
      else $error("reverse enable wrong");
   a_lock_on_limit: assert property (rdy |-> servoLock ==
      !($past(fwd_limit_in, 3) && $past(rev_limit_in, 3))) else $error("servo lock wrong");
   a_prop_follow: assert property (rdy |-> propOnly == $past(prop_ctrl_in, 3))
      else $error("proportional mode wrong");
   a_gain_prio: assert property (rdy |-> gainSet == ($past(gain_sel2_in, 3) ? 2'h2 :
      ($past(gain_sel_in, 3) ? 2'h1 : 2'h0))) else $error("gain set wrong");
   a_probe_edge: assert property (rdy && probeStrobe[0] |->
      $past(probe_latch_in_a, 3) && !$past(probe_latch_in_a, 4) ##1 !probeStrobe[0])
      else $error("probe strobe wrong");
   a_brake_cuts: assert property (dynBrakeOn |-> powerStageOff)
      else $error("brake without power cut");
   a_decel_holds: assert property (decelStopReq |-> brake_interlock_out)
      else $error("interlock dropped during decel");

   c_probe: cover property (probeStrobe[0]);
   c_brake: cover property (dynBrakeOn);
   c_third: cover property (gainSet == 2'h2);
endmodule : servo_input_monitor

bind servo_input_device_decoder servo_input_monitor u_mon (.sys_clk, .reset, .fwd_limit_in,
   .rev_limit_in, .prop_ctrl_in, .gain_sel_in, .gain_sel2_in, .probe_latch_in_a, .fwdEnable,
   .revEnable, .servoLock, .propOnly, .gainSet, .probeStrobe, .dynBrakeOn, .powerStageOff,
   .decelStopReq, .brake_interlock_out);
`default_nettype wire

// ===== switch_sensor_model.sv
// Switches and sensors on the input pins.
// Assumes the bench sets wanted levels on cmd; pins move after an edge.
`timescale 1ns/100ps
`default_nettype none

module switch_sensor_model (
   input  wire logic        sys_clk,
   input  wire logic        torqueMode,
   input  wire logic [11:0] cmd,
   output logic      [11:0] pins
);
   // Proportional input held off in torque mode
   always_ff @(posedge sys_clk) begin
      pins <= {cmd[11:5], cmd[4] & ~torqueMode, cmd[3:0]};
   end
endmodule : switch_sensor_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the servo input decoder.
// Assumes the switch model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic sys_clk = 1'b0, reset = 1'b1, alarm = 1'b0, motorStopped = 1'b0;
   logic [11:0] cmd = 12'h00f, pins;
   logic [31:0] curPosition = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, gainSet, rs;
   logic decelStopReq, powerStageOff, dynBrakeOn, brake_interlock_out, fwdEnable;
   logic revEnable, servoLock, propOnly, fullyClosed, homeDetect;
   logic [2:0] probeStrobe, seen = 3'h0;
   int miscompares = 0, num_checks = 0, cycles = 0;

   always #25 sys_clk = ~sys_clk;

   switch_sensor_model u_sw (.sys_clk, .torqueMode(1'b0), .cmd, .pins);
   servo_input_device_decoder #(.SINGLE_AXIS(1'b1)) u_dut (.sys_clk, .reset,
      .forced_stop_decel_in(pins[0]), .forced_stop_brake_in(pins[1]), .fwd_limit_in(pins[2]),
      .rev_limit_in(pins[3]), .prop_ctrl_in(pins[4]), .gain_sel_in(pins[5]),
      .gain_sel2_in(pins[6]), .closed_loop_sel_in(pins[7]), .home_sensor_in(pins[8]),
      .probe_latch_in_a(pins[9]), .probe_latch_in_b(pins[10]), .probe_latch_in_c(pins[11]),
      .alarm, .motorStopped, .curPosition, .decelStopReq, .powerStageOff, .dynBrakeOn,
      .brake_interlock_out, .fwdEnable, .revEnable, .servoLock, .propOnly, .gainSet,
      .fullyClosed, .homeDetect, .probeStrobe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   always @(posedge sys_clk) seen <= seen | probeStrobe;

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report;
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt

   task automatic pin(input int i, input logic v);
      @(posedge sys_clk);
      cmd[i] <= v;
      wt(7);
   endtask : pin

   // Bus cycles: ready and answer are looked at mid-cycle, acted on at the edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, done;
      done = 1'b0;
      @(posedge sys_clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!done) begin
         @(negedge sys_clk);
         {ta, tw, done, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (done) s_axi_bready <= 1'b0;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic ta, done;
      done = 1'b0;
      @(posedge sys_clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      while (!done) begin
         @(negedge sys_clk);
         {ta, done, rv, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
         @(posedge sys_clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (done) s_axi_rready <= 1'b0;
      end
   endtask : rd

   task automatic t_regs;
      rd(servo_input_pkg::CFG_OFFSET);
      chk("cfg reset", 32'h0, rv);
      rd(servo_input_pkg::PROBE_OFFSET);
      chk("probe enable reset", 32'h3, rv);
      rd(8'h20);
      chk("unmapped resp", servo_input_pkg::RESP_SLVERR, rs);
      wr(servo_input_pkg::STATUS_OFFSET, 32'hffff);
      chk("status write resp", servo_input_pkg::RESP_SLVERR, rs);
      $display("test regs done");
   endtask : t_regs

   task automatic t_inputs;
      logic [1:0] b;
      for (int i = 0; i < 4; i++) begin
         b = 2'(i);
         @(posedge sys_clk);
         cmd[6:2] <= {b[1], b[0], b[0], b[1], b[0]};
         wt(7);
         chk("fwdEnable", b[0], fwdEnable);
         chk("revEnable", b[1], revEnable);
         chk("servoLock", !(&b), servoLock);
         chk("propOnly", b[0], propOnly);
         chk("gainSet", b[1] ? 2'h2 : {1'b0, b[0]}, gainSet);
      end
      $display("test inputs done");
   endtask : t_inputs

   task automatic t_loop_home;
      pin(7, 1'b1);
      chk("fullyClosed off", 1'b0, fullyClosed);
      wr(servo_input_pkg::CFG_OFFSET, 32'h20);
      wt(7);
      chk("fullyClosed on", 1'b1, fullyClosed);
      pin(7, 1'b0);
      chk("semi closed", 1'b0, fullyClosed);
      chk("home pol0 off", 1'b1, homeDetect);
      pin(8, 1'b1);
      chk("home pol0 on", 1'b0, homeDetect);
      wr(servo_input_pkg::CFG_OFFSET, 32'h60);
      wt(7);
      chk("home pol1 on", 1'b1, homeDetect);
      pin(8, 1'b0);
      wr(servo_input_pkg::CFG_OFFSET, 32'h0);
      $display("test loop home done");
   endtask : t_loop_home

   task automatic t_probe;
      curPosition <= 32'h12345678;
      pin(9, 1'b1);
      pin(11, 1'b1);
      chk("strobes default", 3'h1, seen);
      rd(servo_input_pkg::POS_A_OFFSET);
      chk("pos a", 32'h12345678, rv);
      wr(servo_input_pkg::PROBE_OFFSET, 32'h7);
      curPosition <= 32'h0000abcd;
      pin(11, 1'b0);
      pin(11, 1'b1);
      chk("strobe c enabled", 3'h5, seen);
      rd(servo_input_pkg::POS_C_OFFSET);
      chk("pos c", 32'h0000abcd, rv);
      $display("test probe done");
   endtask : t_probe

   task automatic t_stop;
      pin(1, 1'b0);
      chk("brake power off", 3'h6, {powerStageOff, dynBrakeOn, brake_interlock_out});
      pin(1, 1'b1);
      chk("brake cleared", 3'h1, {powerStageOff, dynBrakeOn, brake_interlock_out});
      pin(0, 1'b0);
      chk("decel ignored m0", 1'b0, decelStopReq);
      pin(0, 1'b1);
      wr(servo_input_pkg::CFG_OFFSET, 32'h2);
      pin(0, 1'b0);
      chk("decel stop", 2'h3, {decelStopReq, brake_interlock_out});
      motorStopped <= 1'b1;
      wt(7);
      chk("decel done", 1'b0, brake_interlock_out);
      motorStopped <= 1'b0;
      pin(0, 1'b1);
      chk("decel cleared", 2'h1, {decelStopReq, brake_interlock_out});
      wr(servo_input_pkg::CFG_OFFSET, 32'h12);
      pin(0, 1'b0);
      chk("decel masked", 2'h1, {decelStopReq, brake_interlock_out});
      alarm <= 1'b1;
      wt(7);
      chk("alarm decel", 2'h3, {decelStopReq, brake_interlock_out});
      alarm <= 1'b0;
      wt(7);
      wr(servo_input_pkg::CFG_OFFSET, 32'h10);
      alarm <= 1'b1;
      wt(7);
      chk("alarm at once", 2'h0, {decelStopReq, brake_interlock_out});
      alarm <= 1'b0;
      pin(0, 1'b1);
      $display("test stop done");
   endtask : t_stop

   initial begin
      wt(10);
      reset <= 1'b0;
      t_regs;
      t_inputs;
      t_loop_home;
      t_probe;
      t_stop;
      final_report;
   end
endmodule : tb
`default_nettype wire
